/* rtl/mst_pkg.sv */
package mst_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_KHZ            = 10000;
	localparam int T_INIT_MS          = 2000;
	localparam int T_RESET_MIN_US     = 2;
	localparam int T_PDOWN_OFF_MS     = 300;
	localparam int T_PDOWN_ON_MS      = 100;
	localparam int T_LOW_POWER_SELECT_ON_US     = 100;
	localparam int T_INT_ON_MS        = 200;
	localparam int T_INT_OFF_US       = 500;
	localparam int T_MODSEL_US        = 100;
	localparam int INIT_CYC_DFLT      = T_INIT_MS * CLK_KHZ;
	localparam int PDOWN_OFF_CYC_DFLT = T_PDOWN_OFF_MS * CLK_KHZ;
	localparam int RESET_MIN_CYC      = (T_RESET_MIN_US * CLK_KHZ + 999) / 1000;
	localparam int CNT_W              = 25;
	localparam int RST_CNT_W          = 6;
	localparam logic [RST_CNT_W-1:0] RESET_MIN_VAL = RST_CNT_W'(RESET_MIN_CYC);

	// ==========================================================
	// Register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h00;
	localparam logic [ADDR_W-1:0] REG_FLAGS   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_MASK    = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_STOPS   = 8'h10;
	localparam logic [ADDR_W-1:0] REG_COND    = 8'h14;

	// ==========================================================
	// Field positions and reset values
	localparam int STS_NOT_READY = 0;
	localparam int STS_LOW_POWER = 1;
	localparam int STS_BUS_RESP  = 2;
	localparam int STS_INT       = 3;
	localparam int STS_STATE_LSB = 4;
	localparam int CTL_PDOWN     = 0;
	localparam int NCH           = 4;
	localparam int FLAG_W        = 3 * NCH + 1;
	localparam int STOP_W        = 16;
	localparam logic [FLAG_W-1:0] MASK_RST  = 13'h0000;
	localparam logic [4:0]        PIN_RSTV  = 5'h17;
	localparam logic              PDOWN_RST = 1'b0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_INIT  = 2'b00,
		ST_READY = 2'b01,
		ST_PDOWN = 2'b11,
		ST_HELD  = 2'b10
	} mst_state_t;

	typedef struct packed {
		logic            initDone;
		logic [NCH-1:0]  other;
		logic [NCH-1:0]  txFault;
		logic [NCH-1:0]  los;
	} mst_flags_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [DATA_W-1:0] wdata;
	} mst_apb_req_t;

endpackage

/* rtl/mst_mgmt_top.sv */
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
// What this block does
// [RL1] After power-on, hot plug or reset release, reach fully functional within 2000 ms.
// [RL2] Reset is recognised only if reset pin stays low over 2 us.
// [RL3] Serial bus responding starts no later than 2000 ms after power-on.
// [RL4] Within 2000 ms of power-on clear data-not-ready and assert interrupt.
// [RL5] After reset pin rises, be fully functional again within 2000 ms.
// [RL6] Low-power select high drops to lower power within 100 us.
// [RL7] An interrupt condition drives interrupt output low within 200 ms.
// [RL8] Reading a flag clears it; interrupt releases within 500 us.
// [RL9] Loss-of-signal sets its flag and asserts interrupt within 100 ms.
// [RL10] Transmit fault sets its flag and asserts interrupt within 200 ms.
// [RL11] Any other condition sets its flag and asserts interrupt within 200 ms.
// [RL12] Setting a mask bit inhibits that flag's interrupt within 100 ms.
// [RL13] Clearing a mask bit restores that flag's interrupt within 100 ms.
// [RL14] Serial bus responds within 100 us after module select goes low.
// [RL15] Serial bus stops responding within 100 us after module select goes high.
// [RL16] Power-down bit written one enters lower power within 100 ms.
// [RL17] Power-down bit written zero returns fully functional within 300 ms.
// [RL18] Fully functional means interrupt asserted due to data-not-ready cleared.
// [RL19] Write-caused latencies count from the end of the write transfer.
// [RL20] Host reads the flag field after interrupt to find channel and kind.
// [RL21] Init, power-down exit and reset-pulse timings come from counters on the free-running core clock.

// ==========================================================
// Two-stage synchroniser
module mst_sync2 #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   RSTV = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstB,
	// Data
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rstB) begin
			meta_q  <= RSTV;
			syncOut <= RSTV;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

// ==========================================================
// Management, status and timing top
module mst_mgmt_top
	import mst_pkg::*;
#(
	parameter int INIT_CYC      = INIT_CYC_DFLT,
	parameter int PDOWN_OFF_CYC = PDOWN_OFF_CYC_DFLT
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Module pins
	input  wire logic              module_reset_low,
	input  wire logic              low_power_select,
	input  wire logic              module_select_low,
	input  wire logic              serialClk,
	input  wire logic              serialData,
	output logic                   interrupt_out_low,
	output logic                   serialRespondEn,
	output logic                   lowPowerActive,
	// Channel conditions
	input  wire logic [NCH-1:0]    losCond,
	input  wire logic [NCH-1:0]    txFaultCond,
	input  wire logic [NCH-1:0]    otherCond
);

	localparam logic [CNT_W-1:0] INIT_LAST  = CNT_W'(INIT_CYC - 1);
	localparam logic [CNT_W-1:0] PDOWN_SKIP = CNT_W'(INIT_CYC - PDOWN_OFF_CYC);

	// ==========================================================
	// Input synchronisation
	logic [4:0]         pinSync;
	logic [3*NCH-1:0]   condSync;
	logic               resetPin;
	logic               lpSel;
	logic               selLow;
	logic               sclNow;
	logic               sdaNow;

	mst_sync2 #(
		.W    (5),
		.RSTV (PIN_RSTV)
	) u_pinSync (
		.clk     (core_clk),
		.rstB    (rst_b),
		.asyncIn ({module_reset_low, low_power_select, module_select_low, serialClk, serialData}),
		.syncOut (pinSync)
	);

	mst_sync2 #(
		.W    (3 * NCH),
		.RSTV ('0)
	) u_condSync (
		.clk     (core_clk),
		.rstB    (rst_b),
		.asyncIn ({otherCond, txFaultCond, losCond}),
		.syncOut (condSync)
	);

	assign resetPin = pinSync[4];
	assign lpSel    = pinSync[3];
	assign selLow   = pinSync[2];
	assign sclNow   = pinSync[1];
	assign sdaNow   = pinSync[0];

	// ==========================================================
	// Reset pulse qualification
	logic [RST_CNT_W-1:0] rstLowCnt_q;
	logic                 resetHold;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rstLowCnt_q <= '0;
		end else if (resetPin) begin
			rstLowCnt_q <= '0;
		end else if (rstLowCnt_q != RESET_MIN_VAL) begin
			rstLowCnt_q <= rstLowCnt_q + 1'b1; // [RL2]
		end
	end

	assign resetHold = (rstLowCnt_q == RESET_MIN_VAL); // [RL2]

	// ==========================================================
	// Control registers and APB decode
	mst_apb_req_t      req;
	logic              setup;
	logic              access;
	logic              wrAccess;
	logic              flagsRead;
	logic              addrHit;
	logic [FLAG_W-1:0] mask_q;
	logic              pdownCtl_q;

	assign req       = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign setup     = psel & ~penable;
	assign access    = psel & penable & pready;
	assign wrAccess  = access & req.write;
	assign flagsRead = access & ~req.write & (req.addr == REG_FLAGS);

	always_comb begin
		case (req.addr)
			REG_STATUS,
			REG_FLAGS,
			REG_MASK,
			REG_CONTROL,
			REG_STOPS,
			REG_COND: addrHit = 1'b1;
			default:  addrHit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mask_q <= MASK_RST;
		end else if (wrAccess && (req.addr == REG_MASK)) begin
			mask_q <= req.wdata[FLAG_W-1:0]; // [RL12] [RL13] [RL19]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pdownCtl_q <= PDOWN_RST;
		end else if (wrAccess && (req.addr == REG_CONTROL)) begin
			pdownCtl_q <= req.wdata[CTL_PDOWN]; // [RL19]
		end
	end

	// ==========================================================
	// Power and initialisation state machine
	mst_state_t        state_q;
	logic [CNT_W-1:0]  initCnt_q;
	logic              initDonePulse;
	logic              operational;

	assign initDonePulse = (state_q == ST_INIT) && (initCnt_q == INIT_LAST) && !resetHold;
	assign operational   = (state_q == ST_READY) || (state_q == ST_PDOWN);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_q   <= ST_INIT;
			initCnt_q <= '0;
		end else if (resetHold) begin
			state_q   <= ST_HELD; // [RL2]
			initCnt_q <= '0;
		end else begin
			case (state_q)
				ST_INIT: begin
					if (initCnt_q == INIT_LAST) begin
						state_q   <= ST_READY; // [RL1] [RL3] [RL21]
						initCnt_q <= '0;
					end else begin
						initCnt_q <= initCnt_q + 1'b1; // [RL21]
					end
				end
				ST_READY: begin
					if (pdownCtl_q) begin
						state_q <= ST_PDOWN; // [RL16]
					end
				end
				ST_PDOWN: begin
					if (!pdownCtl_q) begin
						state_q   <= ST_INIT; // [RL17]
						initCnt_q <= PDOWN_SKIP; // [RL17]
					end
				end
				ST_HELD: begin
					if (resetPin) begin
						state_q   <= ST_INIT; // [RL5]
						initCnt_q <= '0;
					end
				end
				default: begin
					state_q   <= ST_INIT;
					initCnt_q <= '0;
				end
			endcase
		end
	end

	// ==========================================================
	// Power level and serial bus response
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lowPowerActive <= 1'b0;
		end else begin
			lowPowerActive <= lpSel || (state_q == ST_PDOWN); // [RL6] [RL16]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			serialRespondEn <= 1'b0;
		end else begin
			serialRespondEn <= operational && !selLow; // [RL3] [RL14] [RL15]
		end
	end

	// ==========================================================
	// Serial bus stop detection
	logic              sdaPrev_q;
	logic              sclPrev_q;
	logic [STOP_W-1:0] stopCnt_q;
	logic              stopSeen;

	assign stopSeen = sclNow && sclPrev_q && sdaNow && !sdaPrev_q;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sdaPrev_q <= 1'b1;
			sclPrev_q <= 1'b1;
		end else begin
			sdaPrev_q <= sdaNow;
			sclPrev_q <= sclNow;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stopCnt_q <= '0;
		end else if (stopSeen && serialRespondEn) begin
			stopCnt_q <= stopCnt_q + 1'b1;
		end
	end

	// ==========================================================
	// Latched flags
	logic [3*NCH-1:0] condPrev_q;
	logic [3*NCH-1:0] condRise;
	mst_flags_t       flagSet;
	mst_flags_t       flags_q;
	logic             intPending;

	assign condRise = condSync & ~condPrev_q;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			condPrev_q <= '0;
		end else begin
			condPrev_q <= condSync;
		end
	end

	always_comb begin
		flagSet          = '0;
		flagSet.initDone = initDonePulse; // [RL4] [RL18]
		if (operational) begin
			flagSet.los     = condRise[NCH-1:0]; // [RL9]
			flagSet.txFault = condRise[2*NCH-1:NCH]; // [RL10]
			flagSet.other   = condRise[3*NCH-1:2*NCH]; // [RL11]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			flags_q <= '0;
		end else if (state_q == ST_HELD) begin
			flags_q <= '0;
		end else if (flagsRead) begin
			flags_q <= (flags_q & ~prdata[FLAG_W-1:0]) | flagSet; // [RL8]
		end else begin
			flags_q <= flags_q | flagSet; // [RL7]
		end
	end

	assign intPending = |(flags_q & ~mask_q); // [RL12] [RL13]

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			interrupt_out_low <= 1'b1;
		end else begin
			interrupt_out_low <= !intPending; // [RL7] [RL8] [RL18]
		end
	end

	// ==========================================================
	// APB answer
	logic [DATA_W-1:0] rdMux;

	always_comb begin
		rdMux = '0;
		case (req.addr)
			REG_STATUS: begin
				rdMux[STS_NOT_READY]                 = !operational; // [RL4]
				rdMux[STS_LOW_POWER]                 = lowPowerActive;
				rdMux[STS_BUS_RESP]                  = serialRespondEn;
				rdMux[STS_INT]                       = !interrupt_out_low;
				rdMux[STS_STATE_LSB+1:STS_STATE_LSB] = state_q;
			end
			REG_FLAGS:   rdMux[FLAG_W-1:0] = flags_q; // [RL20]
			REG_MASK:    rdMux[FLAG_W-1:0] = mask_q;
			REG_CONTROL: rdMux[CTL_PDOWN]  = pdownCtl_q;
			REG_STOPS:   rdMux[STOP_W-1:0] = stopCnt_q;
			REG_COND:    rdMux[3*NCH-1:0]  = condSync;
			default:     rdMux = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !addrHit;
			prdata  <= (setup && !req.write) ? rdMux : '0;
		end
	end

endmodule

/* bench/mst_mgmt_props.sv */
`timescale 1ns/10ps
// ==========================================================
// Port checker
module mst_mgmt_props
	import mst_pkg::*;
#(
	parameter int INIT_CYC      = INIT_CYC_DFLT,
	parameter int PDOWN_OFF_CYC = PDOWN_OFF_CYC_DFLT
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// APB
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	input  wire logic              pready,
	// Pins
	input  wire logic              module_reset_low,
	input  wire logic              low_power_select,
	input  wire logic              module_select_low,
	input  wire logic              interrupt_out_low,
	input  wire logic              serialRespondEn,
	input  wire logic              lowPowerActive,
	// Conditions
	input  wire logic [NCH-1:0]    losCond,
	input  wire logic [NCH-1:0]    txFaultCond,
	input  wire logic [NCH-1:0]    otherCond
);
	// ==========================================================
	// Helper counters
	logic [15:0] initCnt_q;
	logic [5:0]  pinCnt_q;
	logic [5:0]  quiet_q;
	logic [11:0] cond_q;
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			initCnt_q <= 16'h0;
			quiet_q   <= 6'h0;
		end else begin
			initCnt_q <= initCnt_q + {15'h0, initCnt_q < 16'(INIT_CYC + 11)};
			quiet_q   <= ({losCond, txFaultCond, otherCond} != cond_q) ? 6'h0 : quiet_q + {5'h0, quiet_q != 6'h3f};
		end
		cond_q   <= {losCond, txFaultCond, otherCond};
		pinCnt_q <= module_reset_low ? 6'h0 : pinCnt_q + {5'h0, pinCnt_q != 6'h3f};
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence flag_rd;
		psel && penable && pready && !pwrite && paddr == REG_FLAGS;
	endsequence
	sequence ctl_wr;
		psel && penable && pready && pwrite && paddr == REG_CONTROL;
	endsequence
	sequence mask_all;
		psel && penable && pready && pwrite && paddr == REG_MASK && pwdata[FLAG_W-1:0] == 13'h1fff;
	endsequence
	a_init_time: assert property (initCnt_q == 16'(INIT_CYC + 10) |-> !interrupt_out_low)
		else $error("interrupt not asserted after init");
	a_held_quiet: assert property (pinCnt_q == 6'h1e |-> interrupt_out_low && !serialRespondEn)
		else $error("pin reset not recognised");
	a_lp_enter: assert property ($rose(low_power_select) |-> ##[1:1000] lowPowerActive)
		else $error("low power not entered");
	a_int_release: assert property (flag_rd ##0 quiet_q > 6'h8 ##1 (!psel)[*4] |-> interrupt_out_low)
		else $error("interrupt not released after flag read");
	a_mask_inhibit: assert property (mask_all |-> ##[1:8] interrupt_out_low)
		else $error("mask did not inhibit interrupt");
	a_sel_off: assert property ($rose(module_select_low) |-> ##[1:1000] !serialRespondEn)
		else $error("bus still responding after deselect");
	a_pdown_enter: assert property (ctl_wr ##0 pwdata[CTL_PDOWN] |-> ##[1:1000] lowPowerActive)
		else $error("power down not entered");
	a_pdown_exit: assert property (ctl_wr ##0 !pwdata[CTL_PDOWN] && !low_power_select |-> ##[1:1000] !lowPowerActive)
		else $error("power down not left");
endmodule

bind mst_mgmt_top mst_mgmt_props #(.INIT_CYC(INIT_CYC), .PDOWN_OFF_CYC(PDOWN_OFF_CYC)) i_mst_mgmt_props (
	.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .module_reset_low, .low_power_select,
	.module_select_low, .interrupt_out_low, .serialRespondEn, .lowPowerActive, .losCond, .txFaultCond, .otherCond
);

/* bench/mst_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Host end of the 2-wire bus
module mst_host_model (
	// 2-wire bus
	output logic serialClk,
	output logic serialData
);
	// Both lines rest high on the pull-ups
	initial begin
		serialClk  = 1'b1;
		serialData = 1'b1;
	end
	// Start, clocked bits, stop; clock stands high between frames
	task automatic frame(input int nBits);
		#37 serialData = 1'b0;
		#400 serialClk = 1'b0;
		for (int i = 0; i < nBits; i++) begin
			#200 serialData = i[0];
			#200 serialClk = 1'b1;
			#400 serialClk = 1'b0;
		end
		#200 serialData = 1'b0;
		#200 serialClk = 1'b1;
		#400 serialData = 1'b1;
		// Bus free time so the stop is counted before the host moves on
		#500;
	endtask
endmodule

/* bench/mst_mgmt_bench.sv */
`timescale 1ns/10ps
module mst_mgmt_bench;
	import mst_pkg::*;
	localparam int IC = 200;
	localparam int PC = 100;
	// ==========================================================
	// Signals
	logic              core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic              module_reset_low, low_power_select, module_select_low, serialClk, serialData;
	logic              interrupt_out_low, serialRespondEn, lowPowerActive;
	logic [NCH-1:0]    losCond, txFaultCond, otherCond;
	int                bad_count, n_checks;

	mst_mgmt_top #(.INIT_CYC(IC), .PDOWN_OFF_CYC(PC)) i_mst_mgmt_top (
		.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.module_reset_low, .low_power_select, .module_select_low, .serialClk, .serialData,
		.interrupt_out_low, .serialRespondEn, .lowPowerActive, .losCond, .txFaultCond, .otherCond
	);
	mst_host_model i_mst_host_model (.serialClk, .serialData);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// ==========================================================
	// Tasks
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk({31'h0, pready}, 32'h1);
			end_sim();
		end
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic waitSig(input int s, input logic v, input int lim);
		logic cur;
		for (int n = 0; n < lim; n++) begin
			@(posedge core_clk);
			cur = (s == 0) ? interrupt_out_low : (s == 1) ? lowPowerActive : serialRespondEn;
			if (cur === v) break;
		end
		chk({31'h0, cur}, {31'h0, v});
		if (cur !== v) end_sim();
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	// ==========================================================
	// Tests
	initial begin
		{psel, penable, pwrite, low_power_select} = 4'h0;
		{module_reset_low, module_select_low} = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		{otherCond, txFaultCond, losCond} = 12'h000;
		bad_count = 0;
		n_checks = 0;
		rst_b = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		rdc(REG_STATUS, 32'h1);
		rdc(REG_MASK, 32'h0);
		rdc(REG_CONTROL, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk({31'h0, err}, 32'h1);
		waitSig(0, 1'b0, IC + 50);
		repeat (20) @(posedge core_clk);
		rdc(REG_STATUS, 32'h18);
		rdc(REG_FLAGS, 32'h1000);
		waitSig(0, 1'b1, 50);
		rdc(REG_FLAGS, 32'h0);
		tdone("init");
		for (int k = 0; k < 3; k++) begin
			{otherCond, txFaultCond, losCond} <= 12'(1 << (5 * k));
			waitSig(0, 1'b0, 200);
			rdc(REG_FLAGS, 32'h1 << (5 * k));
			waitSig(0, 1'b1, 50);
			{otherCond, txFaultCond, losCond} <= 12'h000;
			repeat (8) @(posedge core_clk);
		end
		tdone("flags");
		losCond <= 4'h8;
		waitSig(0, 1'b0, 50);
		rdc(REG_COND, 32'h8);
		apb(1'b1, REG_MASK, 32'h1fff);
		waitSig(0, 1'b1, 50);
		apb(1'b1, REG_MASK, 32'h0);
		waitSig(0, 1'b0, 50);
		rdc(REG_FLAGS, 32'h8);
		losCond <= 4'h0;
		waitSig(0, 1'b1, 50);
		tdone("mask");
		module_select_low <= 1'b0;
		waitSig(2, 1'b1, 1000);
		i_mst_host_model.frame(8);
		rdc(REG_STOPS, 32'h1);
		rdc(REG_STATUS, 32'h14);
		module_select_low <= 1'b1;
		waitSig(2, 1'b0, 1000);
		i_mst_host_model.frame(3);
		rdc(REG_STOPS, 32'h1);
		tdone("select");
		low_power_select <= 1'b1;
		waitSig(1, 1'b1, 1000);
		low_power_select <= 1'b0;
		waitSig(1, 1'b0, 1000);
		apb(1'b1, REG_CONTROL, 32'h1);
		waitSig(1, 1'b1, 1000);
		rdc(REG_STATUS, 32'h32);
		apb(1'b1, REG_CONTROL, 32'h0);
		waitSig(0, 1'b0, PC + 50);
		rdc(REG_FLAGS, 32'h1000);
		waitSig(0, 1'b1, 50);
		tdone("power");
		module_reset_low <= 1'b0;
		repeat (15) @(posedge core_clk);
		module_reset_low <= 1'b1;
		repeat (5) @(posedge core_clk);
		rdc(REG_STATUS, 32'h10);
		module_reset_low <= 1'b0;
		repeat (30) @(posedge core_clk);
		rdc(REG_STATUS, 32'h21);
		module_reset_low <= 1'b1;
		waitSig(0, 1'b0, IC + 50);
		rdc(REG_FLAGS, 32'h1000);
		tdone("pin reset");
		end_sim();
	end
endmodule
